// ==== rtl/pwmc_channels.sv ====
`timescale 1ns/100ps

// Contract
// - A scan with the rung true starts the channel out of idle.
// - Run phase drives the chosen pin at commanded frequency and duty.
// - A scan with the rung false stops the waveform and returns idle.
// - Generator runs alone; status words refresh on every instruction scan.
// - Two independent elements, each driving embedded output 2 or 3.
// - Pin selection holds 2 or 3, fixed by configuration, read-only.
// - Only the two embedded outputs are ever driven.
// - Ramp-down flag is high exactly during deceleration.
// - Steady flag is high exactly during the run phase.
// - Frequency words are 16 bits, 0..20000 signed or 0..40000 unsigned.
// - Duty command writable, duty status read-only, both 0..1000.
// - Ramp delay word is 16 bits, 0..32767, for accel and decel.
// - Read-only fault code word carries signed codes -2..5.
// - Phase, fault, health flags read-only; ramp select, hard stop writable.
// - Frequency command outside the variant range raises a channel error.
// - Ramp select 1 ramps frequency, 0 ramps duty; frozen while running.
// - Hard stop halts at once, output low, and raises an error.
// - Quiet flag is high when idle, low when running.
module pwmc_channels #(
    parameter bit WIDE_RANGE = 1'b0
) (
    // Clock and reset
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_n_in,
    // Instruction scan, one per element
    input  wire logic [1:0]           scan_in,
    input  wire logic [1:0]           rung_in,
    // Control words
    input  wire logic [1:0][15:0]     freq_cmd_in,
    input  wire logic [1:0][15:0]     duty_cmd_in,
    input  wire logic [1:0][15:0]     ramp_delay_in,
    input  wire logic [1:0]           ramp_target_sel_in,
    input  wire logic [1:0]           halt_now_in,
    // Configuration
    input  wire logic [1:0][15:0]     pin_cfg_in,
    // Status bits
    output logic [1:0]                ramp_down_flag_out,
    output logic [1:0]                steady_flag_out,
    output logic [1:0]                ramp_up_flag_out,
    output logic [1:0]                quiet_flag_out,
    output logic [1:0]                fault_flag_out,
    output logic [1:0]                healthy_flag_out,
    output logic [1:0]                active_flag_out,
    // Status words
    output logic [1:0][15:0]          pin_sel_word_out,
    output logic [1:0][15:0]          freq_live_out,
    output logic [1:0][15:0]          duty_live_out,
    output logic [1:0][15:0]          fault_code_out,
    // Embedded outputs: bit 0 is output 2, bit 1 is output 3
    output logic [1:0]                emb_pin_out
);

    localparam int N = pwmc_pkg::NCH;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pwmc_pkg::pwmc_state_t state_r   [N];
    pwmc_pkg::pwmc_state_t state_nxt [N];

    logic [N-1:0]                    en_r;
    logic [N-1:0]                    sel_r;
    logic                            cfg_done_r;
    logic [N-1:0][15:0]              pin_r;
    logic [N-1:0][15:0]              err_r;
    logic [N-1:0][15:0]              err_nxt;
    logic [N-1:0][15:0]              ramp_val_r;
    logic [N-1:0][15:0]              ramp_cnt_r;
    logic [pwmc_pkg::TICK_W-1:0]     tick_cnt_r;
    logic                            tick_r;

    logic [N-1:0][15:0]              cfg_code;
    logic [N-1:0][15:0]              tgt_c;
    logic [N-1:0][15:0]              freq_run;
    logic [N-1:0][15:0]              duty_run;
    logic [N-1:0]                    step_c;
    logic [N-1:0]                    run_c;
    logic [N-1:0]                    wave_c;

    logic [1:0]                      ramp_down_r;
    logic [1:0]                      steady_r;
    logic [1:0]                      ramp_up_r;
    logic [1:0]                      quiet_r;
    logic [1:0]                      fault_r;
    logic [1:0]                      healthy_r;
    logic [1:0][15:0]                freq_live_r;
    logic [1:0][15:0]                duty_live_r;
    logic [1:0][15:0]                fault_code_r;
    logic [1:0]                      emb_r;

    // ------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------

    // pin fixed once
    // Taken on the first clock after reset release, never again, so
    // the running program cannot move a channel to another pin
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cfg_done_r <= 1'b0;
            pin_r      <= '0;
        end else if (!cfg_done_r) begin
            cfg_done_r <= 1'b1;
            pin_r      <= pin_cfg_in;
        end
    end

    // pin validity check
    // Bad pin gives -1; two valid elements on one pin give -2 to both
    always_comb begin
        for (int c = 0; c < N; c++) begin
            if (pin_r[c] != pwmc_pkg::PIN_LO && pin_r[c] != pwmc_pkg::PIN_HI)
                cfg_code[c] = pwmc_pkg::ERR_PIN;
            else if (pin_r[0] == pin_r[1])
                cfg_code[c] = pwmc_pkg::ERR_OVERLAP;
            else
                cfg_code[c] = pwmc_pkg::ERR_NONE;
        end
    end

    // ------------------------------------------------------------
    // Program scan and ramp time base
    // ------------------------------------------------------------

    // rung sampled on scan
    // The rung only counts when the instruction is evaluated
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in)
            en_r <= '0;
        else begin
            for (int c = 0; c < N; c++) begin
                if (scan_in[c])
                    en_r[c] <= rung_in[c];
            end
        end
    end

    // ramp select frozen
    // Follows the program only while idle; a running profile keeps
    // the component it started with
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in)
            sel_r <= '0;
        else begin
            for (int c = 0; c < N; c++) begin
                if (state_r[c] == pwmc_pkg::ST_IDLE)
                    sel_r[c] <= ramp_target_sel_in[c];
            end
        end
    end

    // One-cycle enable every microsecond for the ramp counters
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == pwmc_pkg::TICK_W'(pwmc_pkg::RAMP_TICK_CYC - 1)) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Profile values
    // ------------------------------------------------------------

    // ramped component select
    // The ramp value stands in for whichever component is ramped; the
    // other follows its command word directly
    always_comb begin
        for (int c = 0; c < N; c++) begin
            tgt_c[c]    = sel_r[c] ? freq_cmd_in[c]
                                   : pwmc_pkg::duty_fix(duty_cmd_in[c]);
            freq_run[c] = sel_r[c] ? ramp_val_r[c] : freq_cmd_in[c];
            duty_run[c] = sel_r[c] ? pwmc_pkg::duty_fix(duty_cmd_in[c])
                                   : ramp_val_r[c];
            step_c[c]   = tick_r &&
                          ({1'b0, ramp_cnt_r[c]} + 17'h00001 >= {1'b0, ramp_delay_in[c]});
            run_c[c]    = state_r[c] == pwmc_pkg::ST_ACCEL ||
                          state_r[c] == pwmc_pkg::ST_RUN ||
                          state_r[c] == pwmc_pkg::ST_DECEL;
        end
    end

    // ------------------------------------------------------------
    // Channel state machines
    // ------------------------------------------------------------

    always_comb begin
        logic [15:0] trip;
        logic        nodly;
        trip  = pwmc_pkg::ERR_NONE;
        nodly = 1'b0;
        for (int c = 0; c < N; c++) begin
            trip         = pwmc_pkg::ERR_NONE;
            nodly        = ramp_delay_in[c] == pwmc_pkg::RESET_WORD;
            state_nxt[c] = state_r[c];
            err_nxt[c]   = err_r[c];
            if (halt_now_in[c])
                trip = pwmc_pkg::ERR_HALT;
            else if (!pwmc_pkg::freq_ok(freq_cmd_in[c], WIDE_RANGE))
                trip = pwmc_pkg::ERR_FREQ;
            unique case (state_r[c])
                pwmc_pkg::ST_IDLE: begin
                    err_nxt[c] = cfg_code[c];
                    if (en_r[c] && cfg_code[c] == pwmc_pkg::ERR_NONE) begin
                        if (trip != pwmc_pkg::ERR_NONE) begin
                            state_nxt[c] = pwmc_pkg::ST_STOP;
                            err_nxt[c]   = trip;
                        end else if (nodly)
                            state_nxt[c] = pwmc_pkg::ST_RUN;
                        else
                            state_nxt[c] = pwmc_pkg::ST_ACCEL;
                    end
                end
                pwmc_pkg::ST_ACCEL: begin
                    if (trip != pwmc_pkg::ERR_NONE) begin
                        state_nxt[c] = pwmc_pkg::ST_STOP;
                        err_nxt[c]   = trip;
                    end else if (!en_r[c])
                        state_nxt[c] = nodly ? pwmc_pkg::ST_IDLE : pwmc_pkg::ST_DECEL;
                    else if (ramp_val_r[c] >= tgt_c[c])
                        state_nxt[c] = pwmc_pkg::ST_RUN;
                end
                pwmc_pkg::ST_RUN: begin
                    if (trip != pwmc_pkg::ERR_NONE) begin
                        state_nxt[c] = pwmc_pkg::ST_STOP;
                        err_nxt[c]   = trip;
                    end else if (!en_r[c])
                        state_nxt[c] = nodly ? pwmc_pkg::ST_IDLE : pwmc_pkg::ST_DECEL;
                end
                pwmc_pkg::ST_DECEL: begin
                    if (trip != pwmc_pkg::ERR_NONE) begin
                        state_nxt[c] = pwmc_pkg::ST_STOP;
                        err_nxt[c]   = trip;
                    end else if (en_r[c])
                        state_nxt[c] = pwmc_pkg::ST_ACCEL;
                    else if (ramp_val_r[c] == pwmc_pkg::RESET_WORD)
                        state_nxt[c] = pwmc_pkg::ST_IDLE;
                end
                pwmc_pkg::ST_STOP: begin
                    // cleared by false rung
                    // Needs both a false rung and hard stop released
                    if (!en_r[c] && !halt_now_in[c]) begin
                        state_nxt[c] = pwmc_pkg::ST_IDLE;
                        err_nxt[c]   = pwmc_pkg::ERR_NONE;
                    end
                end
                default: begin
                    state_nxt[c] = pwmc_pkg::ST_IDLE;
                    err_nxt[c]   = pwmc_pkg::ERR_NONE;
                end
            endcase
        end
    end

    // State and live fault code registers
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            for (int c = 0; c < N; c++)
                state_r[c] <= pwmc_pkg::ST_IDLE;
            err_r <= '0;
        end else begin
            for (int c = 0; c < N; c++)
                state_r[c] <= state_nxt[c];
            err_r <= err_nxt;
        end
    end

    // Ramp value and delay counter; steered by next state so the
    // value is already at target on the first run cycle
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ramp_val_r <= '0;
            ramp_cnt_r <= '0;
        end else begin
            for (int c = 0; c < N; c++) begin
                unique case (state_nxt[c])
                    pwmc_pkg::ST_IDLE,
                    pwmc_pkg::ST_STOP: begin
                        ramp_val_r[c] <= '0;
                        ramp_cnt_r[c] <= '0;
                    end
                    pwmc_pkg::ST_RUN: begin
                        ramp_val_r[c] <= tgt_c[c];
                        ramp_cnt_r[c] <= '0;
                    end
                    pwmc_pkg::ST_ACCEL: begin
                        if (step_c[c])
                            ramp_val_r[c] <= (ramp_val_r[c] >= tgt_c[c]) ? tgt_c[c]
                                                                        : ramp_val_r[c] + 1'b1;
                        if (tick_r)
                            ramp_cnt_r[c] <= step_c[c] ? '0 : ramp_cnt_r[c] + 1'b1;
                    end
                    pwmc_pkg::ST_DECEL: begin
                        if (step_c[c] && ramp_val_r[c] != pwmc_pkg::RESET_WORD)
                            ramp_val_r[c] <= ramp_val_r[c] - 1'b1;
                        if (tick_r)
                            ramp_cnt_r[c] <= step_c[c] ? '0 : ramp_cnt_r[c] + 1'b1;
                    end
                    default: begin
                        ramp_val_r[c] <= '0;
                        ramp_cnt_r[c] <= '0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Waveform generators
    // ------------------------------------------------------------

    for (genvar g = 0; g < N; g++) begin : gen_wave
        pwmc_wave u_wave (
            .clk_sys_in (clk_sys_in),
            .rst_n_in   (rst_n_in),
            .run_in     (run_c[g]),
            .freq_in    (freq_run[g]),
            .duty_in    (duty_run[g]),
            .wave_out   (wave_c[g])
        );
    end

    // embedded pins only
    // Each pin ORs the elements that own it; the overlap check keeps
    // two running elements from ever sharing one
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in)
            emb_r <= '0;
        else begin
            for (int p = 0; p < 2; p++) begin
                emb_r[p] <= 1'b0;
                for (int c = 0; c < N; c++) begin
                    if (run_c[c] && state_nxt[c] != pwmc_pkg::ST_STOP &&
                        state_nxt[c] != pwmc_pkg::ST_IDLE &&
                        pin_r[c] == pwmc_pkg::PIN_LO + 16'(p) && wave_c[c])
                        emb_r[p] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------

    // phase flags exclusive
    // Taken from the next state so each flag matches the phase exactly
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ramp_up_r   <= '0;
            steady_r    <= '0;
            ramp_down_r <= '0;
            quiet_r     <= '1;
            fault_r     <= '0;
            healthy_r   <= '0;
        end else begin
            for (int c = 0; c < N; c++) begin
                ramp_up_r[c]   <= state_nxt[c] == pwmc_pkg::ST_ACCEL;
                steady_r[c]    <= state_nxt[c] == pwmc_pkg::ST_RUN;
                ramp_down_r[c] <= state_nxt[c] == pwmc_pkg::ST_DECEL;
                quiet_r[c]     <= state_nxt[c] == pwmc_pkg::ST_IDLE;
                fault_r[c]     <= err_nxt[c] != pwmc_pkg::ERR_NONE;
                healthy_r[c]   <= err_nxt[c] == pwmc_pkg::ERR_NONE &&
                                  (state_nxt[c] == pwmc_pkg::ST_ACCEL ||
                                   state_nxt[c] == pwmc_pkg::ST_RUN ||
                                   state_nxt[c] == pwmc_pkg::ST_DECEL);
            end
        end
    end

    // words refresh on scan
    // Words are only as fresh as the last scan, as software expects;
    // an idle channel reports zero frequency and duty
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            freq_live_r  <= '0;
            duty_live_r  <= '0;
            fault_code_r <= '0;
        end else begin
            for (int c = 0; c < N; c++) begin
                if (scan_in[c]) begin
                    freq_live_r[c]  <= run_c[c] ? freq_run[c] : pwmc_pkg::RESET_WORD;
                    duty_live_r[c]  <= run_c[c] ? duty_run[c] : pwmc_pkg::RESET_WORD;
                    fault_code_r[c] <= err_r[c];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign ramp_down_flag_out = ramp_down_r;
    assign steady_flag_out    = steady_r;
    assign ramp_up_flag_out   = ramp_up_r;
    assign quiet_flag_out     = quiet_r;
    assign fault_flag_out     = fault_r;
    assign healthy_flag_out   = healthy_r;
    assign active_flag_out    = en_r;
    assign pin_sel_word_out   = pin_r;
    assign freq_live_out      = freq_live_r;
    assign duty_live_out      = duty_live_r;
    assign fault_code_out     = fault_code_r;
    assign emb_pin_out        = emb_r;

endmodule : pwmc_channels

// ==== rtl/pwmc_pkg.sv ====
package pwmc_pkg;

    // ------------------------------------------------------------
    // Structure and timing
    // ------------------------------------------------------------
    localparam int NCH           = 2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_HZ        = 100_000_000;
    // Ramp time base: one step slot per microsecond
    localparam int RAMP_TICK_NS  = 1000;
    localparam int RAMP_TICK_CYC = (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W        = 7;
    localparam int ACC_W         = 40;

    // ------------------------------------------------------------
    // Value ranges and pin codes
    // ------------------------------------------------------------
    localparam logic [15:0] FREQ_MAX_NARROW = 16'h4e20;
    localparam logic [15:0] FREQ_MAX_WIDE   = 16'h9c40;
    localparam logic [15:0] DUTY_MAX        = 16'h03e8;
    localparam logic [15:0] PIN_LO          = 16'h0002;
    localparam logic [15:0] PIN_HI          = 16'h0003;
    localparam logic [15:0] RESET_WORD      = 16'h0000;

    // Phase accumulator spans one period as CLK_HZ * DUTY_MAX units
    localparam logic [ACC_W-1:0] CLK_HZ_W   = ACC_W'(CLK_HZ);
    localparam logic [ACC_W-1:0] DUTY_SCALE = ACC_W'(DUTY_MAX);
    localparam logic [ACC_W-1:0] ACC_SPAN   = CLK_HZ_W * DUTY_SCALE;

    // ------------------------------------------------------------
    // Fault codes (two's complement)
    // ------------------------------------------------------------
    localparam logic [15:0] ERR_NONE    = 16'h0000;
    localparam logic [15:0] ERR_HALT    = 16'h0001;
    localparam logic [15:0] ERR_FREQ    = 16'h0003;
    localparam logic [15:0] ERR_PIN     = 16'hffff;
    localparam logic [15:0] ERR_OVERLAP = 16'hfffe;

    // Gray codes along idle, accel, run, decel
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ACCEL = 3'h1,
        ST_RUN   = 3'h3,
        ST_DECEL = 3'h2,
        ST_STOP  = 3'h6
    } pwmc_state_t;

    // Negative duty reads as off, large duty saturates at full on
    function automatic logic [15:0] duty_fix(input logic [15:0] d);
        if (d[15])
            return RESET_WORD;
        else if (d > DUTY_MAX)
            return DUTY_MAX;
        else
            return d;
    endfunction : duty_fix

    // Narrow variant is signed, wide variant unsigned
    function automatic logic freq_ok(input logic [15:0] f, input logic wide);
        if (wide)
            return f <= FREQ_MAX_WIDE;
        else
            return !f[15] && (f <= FREQ_MAX_NARROW);
    endfunction : freq_ok

endpackage : pwmc_pkg

// ==== rtl/pwmc_wave.sv ====
`timescale 1ns/100ps

module pwmc_wave (
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // Waveform command
    input  wire logic        run_in,
    input  wire logic [15:0] freq_in,
    input  wire logic [15:0] duty_in,
    // Waveform
    output logic             wave_out
);

    logic [pwmc_pkg::ACC_W-1:0] acc_r;
    logic [pwmc_pkg::ACC_W-1:0] acc_sum;
    logic [pwmc_pkg::ACC_W-1:0] acc_nxt;
    logic [pwmc_pkg::ACC_W-1:0] inc_c;
    logic [pwmc_pkg::ACC_W-1:0] thresh_c;

    // Exact frequency without a divider: add freq*1000 per clock,
    // wrap at CLK_HZ*1000; high while below duty*CLK_HZ
    always_comb begin
        inc_c    = {24'h000000, freq_in} * pwmc_pkg::DUTY_SCALE;
        thresh_c = {24'h000000, duty_in} * pwmc_pkg::CLK_HZ_W;
        acc_sum  = acc_r + inc_c;
        if (acc_sum >= pwmc_pkg::ACC_SPAN)
            acc_nxt = acc_sum - pwmc_pkg::ACC_SPAN;
        else
            acc_nxt = acc_sum;
    end

    // Phase and output flop; stopped generator holds the pin low
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !run_in) begin
            acc_r    <= '0;
            wave_out <= 1'b0;
        end else begin
            acc_r    <= acc_nxt;
            wave_out <= acc_r < thresh_c;
        end
    end

endmodule : pwmc_wave

// ==== test/pwmc_channels_tb.sv ====
`timescale 1ns/100ps
module pwmc_channels_tb;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, clr = 1'b1;
    logic [1:0] scan = '0, rung = '0, sel = '0, halt = '0, dn, st, up, qt, ft, ok, ac, pin;
    logic [1:0][15:0] freq = '0, duty = '0, dly = '0, cfg = {16'h0003, 16'h0002};
    logic [1:0][15:0] psel, fl, dl, fc, hi;
    int n_fail = 0, comparisons = 0, c;
    // Rows: element, frequency, duty, high cycles in one period
    logic [15:0] rows [4][4] = '{'{16'h0, 16'h9c40, 16'h01f4, 16'h04e2},
        '{16'h1, 16'h9c40, 16'h00fa, 16'h0271}, '{16'h0, 16'h4e20, 16'h02ee, 16'h0ea6},
        '{16'h1, 16'h4e20, 16'h03e8, 16'h1388}};
    pwmc_channels #(.WIDE_RANGE(1'b1)) u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .scan_in(scan), .rung_in(rung), .freq_cmd_in(freq), .duty_cmd_in(duty),
        .ramp_delay_in(dly), .ramp_target_sel_in(sel), .halt_now_in(halt), .pin_cfg_in(cfg),
        .ramp_down_flag_out(dn), .steady_flag_out(st), .ramp_up_flag_out(up),
        .quiet_flag_out(qt), .fault_flag_out(ft), .healthy_flag_out(ok),
        .active_flag_out(ac), .pin_sel_word_out(psel), .freq_live_out(fl),
        .duty_live_out(dl), .fault_code_out(fc), .emb_pin_out(pin));
    pwmc_field u_fld (.clk_sys_in(clk_sys_in), .clr_in(clr), .pin_in(pin), .hi_cnt_out(hi));
    always #5 clk_sys_in = ~clk_sys_in;
    task automatic w(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : w
    // One scan of element e; the extra cycle lets the state and status bits land
    task automatic do_scan(input int e, input logic r);
        scan[e] = 1'b1;
        rung[e] = r;
        w(1);
        scan[e] = 1'b0;
        w(1);
    endtask : do_scan
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask : chk
    task end_of_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // Watchdog: the whole run needs a little under half of this span
    initial begin
        #1_000_000;
        n_fail++;
        end_of_test();
    end
    initial begin
        w(8);
        rst_n_in = 1'b1;
        w(3);
        chk("quiet", 16'h0003, 16'(qt));
        chk("pins", 16'h0302, {psel[1][7:0], psel[0][7:0]});
        foreach (rows[i]) begin
            c = int'(rows[i][0]);
            freq[c] = rows[i][1];
            duty[c] = rows[i][2];
            do_scan(c, 1'b1);
            w(3000);
            clr = 1'b0;
            w(100_000_000 / int'(rows[i][1]));
            clr = 1'b1;
            chk("steady", 16'h0001, 16'(st[c]));
            chk("high time", rows[i][3], (hi[c] + 16'h1 - rows[i][3] <= 16'h2) ? rows[i][3] : hi[c]);
            do_scan(c, 1'b0);
            w(2);
            chk("idle pin", 16'h0000, 16'(pin));
        end
        do_scan(0, 1'b1);
        w(10);
        halt[0] = 1'b1;
        w(3);
        chk("halt pin", 16'h0001, {15'h0, ft[0] & ~pin[0]});
        do_scan(0, 1'b1);
        chk("halt code", 16'h0001, fc[0]);
        do_scan(0, 1'b0);
        halt[0] = 1'b0;
        w(3);
        do_scan(0, 1'b0);
        chk("cleared", 16'h0001, {fc[0][14:0], qt[0]});
        freq[0] = 16'h9c41;
        do_scan(0, 1'b1);
        w(3);
        do_scan(0, 1'b1);
        chk("freq code", 16'h0003, fc[0]);
        do_scan(0, 1'b0);
        freq[0] = 16'h9c40;
        duty[0] = 16'h0032;
        dly[0] = 16'h0001;
        w(3);
        do_scan(0, 1'b1);
        w(10);
        chk("ramp up", 16'h0001, 16'(up[0]));
        w(6000);
        do_scan(0, 1'b1);
        chk("duty live", 16'h0032, dl[0]);
        do_scan(0, 1'b0);
        w(10);
        chk("ramp down", 16'h0001, 16'(dn[0]));
        w(6000);
        chk("back idle", 16'h0001, 16'(qt[0]));
        sel[0] = 1'b1;
        freq[0] = 16'h003c;
        do_scan(0, 1'b1);
        sel[0] = 1'b0;
        w(2000);
        do_scan(0, 1'b1);
        chk("duty held", 16'h0032, dl[0]);
        w(4500);
        do_scan(0, 1'b1);
        chk("freq ramp", 16'h003c, fl[0]);
        rst_n_in = 1'b0;
        cfg[1] = 16'h0002;
        w(8);
        rst_n_in = 1'b1;
        w(3);
        do_scan(0, 1'b1);
        w(3);
        do_scan(0, 1'b1);
        chk("overlap", 16'hfffe, fc[0]);
        end_of_test();
    end
endmodule : pwmc_channels_tb

// ==== test/pwmc_chk.sv ====
`timescale 1ns/100ps
module pwmc_chk (
    input wire logic             clk_sys_in,
    input wire logic             rst_n_in,
    input wire logic [1:0]       scan_in, rung_in, halt_now_in, emb_pin_out,
    input wire logic [1:0]       ramp_up_flag_out, steady_flag_out, ramp_down_flag_out,
    input wire logic [1:0]       quiet_flag_out, fault_flag_out, healthy_flag_out,
    input wire logic [1:0]       active_flag_out,
    input wire logic [1:0][15:0] ramp_delay_in, pin_sel_word_out, freq_live_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // Overlapping pins refuse the start, so only distinct pins are judged
    wire cfg_ok = pin_sel_word_out[0] == 16'h0002 && pin_sel_word_out[1] == 16'h0003;
    a_phase_onehot: assert property (
        $onehot0({ramp_up_flag_out[0], steady_flag_out[0], ramp_down_flag_out[0]}))
        else $error("two phase flags high");
    a_idle_phases: assert property (quiet_flag_out[0] |-> !healthy_flag_out[0] &&
        !ramp_up_flag_out[0] && !steady_flag_out[0] && !ramp_down_flag_out[0])
        else $error("phase flag while idle");
    a_start_lat: assert property (scan_in[0] && rung_in[0] && quiet_flag_out[0] &&
        cfg_ok && !halt_now_in[0] |=> active_flag_out[0] ##1 !quiet_flag_out[0])
        else $error("start latency wrong");
    a_stop_lat: assert property (scan_in[0] && !rung_in[0] && steady_flag_out[0] &&
        ramp_delay_in[0] == 16'h0000 && !halt_now_in[0]
        |=> !active_flag_out[0] ##1 quiet_flag_out[0]) else $error("stop latency wrong");
    a_halt_flags: assert property (halt_now_in[0] && steady_flag_out[0] |=>
        fault_flag_out[0] && !healthy_flag_out[0] && !steady_flag_out[0])
        else $error("hard stop flags wrong");
    a_halt_pin_low: assert property (halt_now_in[0] && steady_flag_out[0] && cfg_ok
        |-> ##2 !emb_pin_out[0] [*3]) else $error("pin active after hard stop");
    a_idle_pin_low: assert property (&quiet_flag_out |-> emb_pin_out == 2'b00)
        else $error("pin active while idle");
    a_pin_fixed: assert property ($past(rst_n_in, 2) |-> $stable(pin_sel_word_out))
        else $error("pin selection changed");
    a_live_hold: assert property (!scan_in[0] && !$past(scan_in[0]) |->
        $stable(freq_live_out[0])) else $error("live word moved without scan");
    c_run: cover property (steady_flag_out[0]);
    c_decel: cover property (ramp_down_flag_out[0]);
    c_fault: cover property (fault_flag_out[0]);
endmodule : pwmc_chk
bind pwmc_channels pwmc_chk u_chk (.*);

// ==== test/pwmc_field.sv ====
`timescale 1ns/100ps
// Field load on the two embedded outputs; it counts the cycles that each pin spends high
module pwmc_field (
    input  wire logic             clk_sys_in,
    input  wire logic             clr_in,
    input  wire logic [1:0]       pin_in,
    output logic      [1:0][15:0] hi_cnt_out
);
    // A clear opens a fresh window, so one period yields the exact on-time
    always_ff @(posedge clk_sys_in) begin
        for (int i = 0; i < 2; i++)
            hi_cnt_out[i] <= clr_in ? 16'h0000 : hi_cnt_out[i] + 16'(pin_in[i]);
    end
endmodule : pwmc_field
